/* pkg/abbe_pkg.sv */
// Constants and types shared by the AND / bit-clear / branch execution slice.
// Assumes a single 200 MHz core clock split into four quadrature phases.
package abbe_pkg;

   //////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int ABBE_CLK_PERIOD_PS = 5000;
   localparam int ABBE_PHASES = 4;
   localparam int ABBE_ICYC_PS = ABBE_CLK_PERIOD_PS * ABBE_PHASES;

   //////////////////////////////////////////////////////////////////////
   // Widths.
   localparam int ABBE_PC_W = 16;
   localparam int ABBE_FA_W = 12;
   localparam logic [ABBE_PC_W-1:0] ABBE_PC_STEP = 16'h0002;
   localparam logic [ABBE_PC_W-1:0] ABBE_PC_RST = 16'h0000;

   //////////////////////////////////////////////////////////////////////
   // Opcode prefixes and branch condition codes.
   localparam logic [5:0] ABBE_PFX_AND = 6'h05;
   localparam logic [3:0] ABBE_PFX_BCLR = 4'h9;
   localparam logic [4:0] ABBE_PFX_BR = 5'h1C;
   localparam logic [2:0] ABBE_CC_ZCLR = 3'h1;
   localparam logic [2:0] ABBE_CC_CSET = 3'h2;
   localparam logic [2:0] ABBE_CC_CCLR = 3'h3;
   localparam logic [2:0] ABBE_CC_OCLR = 3'h5;
   localparam logic [2:0] ABBE_CC_NSET = 3'h6;
   localparam logic [2:0] ABBE_CC_NCLR = 3'h7;

   //////////////////////////////////////////////////////////////////////
   // Addressing.
   localparam logic [7:0] ABBE_IDX_LIMIT = 8'h5F;
   localparam logic [7:0] ABBE_ACC_SPLIT = 8'h60;
   localparam logic [3:0] ABBE_ACC_LO_BANK = 4'h0;
   localparam logic [3:0] ABBE_ACC_HI_BANK = 4'hF;

   //////////////////////////////////////////////////////////////////////
   // Status bit positions.
   localparam int ABBE_ST_C = 0;
   localparam int ABBE_ST_DC = 1;
   localparam int ABBE_ST_Z = 2;
   localparam int ABBE_ST_OVF = 3;
   localparam int ABBE_ST_N = 4;
   localparam int ABBE_ST_W = 5;

   //////////////////////////////////////////////////////////////////////
   // Register port map and fields.
   localparam logic [7:0] ABBE_REG_CTRL = 8'h00;
   localparam logic [7:0] ABBE_REG_WORK = 8'h04;
   localparam logic [7:0] ABBE_REG_BANK = 8'h08;
   localparam logic [7:0] ABBE_REG_STAT = 8'h0C;
   localparam logic [7:0] ABBE_REG_PC = 8'h10;
   localparam logic [7:0] ABBE_REG_IDX = 8'h14;
   localparam logic [7:0] ABBE_REG_FPTR = 8'h18;
   localparam logic [7:0] ABBE_REG_FDATA = 8'h1C;
   localparam logic [7:0] ABBE_REG_EXEC = 8'h20;
   localparam int ABBE_CTRL_RUN = 0;
   localparam int ABBE_CTRL_EXT = 1;
   localparam logic [1:0] ABBE_CTRL_RST = 2'h0;
   localparam logic [7:0] ABBE_WORK_RST = 8'h00;
   localparam logic [3:0] ABBE_BANK_RST = 4'h0;
   localparam logic [4:0] ABBE_STAT_RST = 5'h00;
   localparam logic [11:0] ABBE_IDX_RST = 12'h000;

   //////////////////////////////////////////////////////////////////////
   // Types.
   typedef enum logic [3:0] {
      ABBE_Q1 = 4'b0001,
      ABBE_Q2 = 4'b0010,
      ABBE_Q3 = 4'b0100,
      ABBE_Q4 = 4'b1000
   } abbe_phase_t;

   typedef enum logic [3:0] {
      ABBE_OP_NONE = 4'b0001,
      ABBE_OP_AND = 4'b0010,
      ABBE_OP_BCLR = 4'b0100,
      ABBE_OP_BR = 4'b1000
   } abbe_op_t;

endpackage : abbe_pkg

/* src/abbe_decode.sv */
// Opcode decoder for the execution slice: fields, class and branch test.
// Assumes the opcode is held stable for a whole instruction cycle.
`timescale 1ns/10ps
`default_nettype none

module abbe_decode (
   // Instruction and flags.
   input wire logic [15:0] opcode,
   input wire logic [abbe_pkg::ABBE_ST_W-1:0] status,
   // Decoded fields.
   output var abbe_pkg::abbe_op_t op,
   output logic dest,
   output logic acc,
   output logic [2:0] bit_idx,
   output logic [7:0] faddr,
   output logic [7:0] br_ofs,
   output logic br_take
);
   import abbe_pkg::*;

   ///////////////////////////////////////////////////////////////////////
   // Branch condition codes handled by this slice.
   function automatic logic cc_known(input logic [2:0] cc);
      cc_known = (cc == ABBE_CC_ZCLR) || (cc == ABBE_CC_CSET) ||
                 (cc == ABBE_CC_CCLR) || (cc == ABBE_CC_OCLR) ||
                 (cc == ABBE_CC_NSET) || (cc == ABBE_CC_NCLR);
   endfunction : cc_known

   function automatic logic cc_met(input logic [2:0] cc,
                                   input logic [ABBE_ST_W-1:0] st);
      case (cc)
         ABBE_CC_CSET: cc_met = st[ABBE_ST_C];
         ABBE_CC_NSET: cc_met = st[ABBE_ST_N];
         ABBE_CC_CCLR: cc_met = !st[ABBE_ST_C];
         ABBE_CC_NCLR: cc_met = !st[ABBE_ST_N];
         ABBE_CC_OCLR: cc_met = !st[ABBE_ST_OVF];
         ABBE_CC_ZCLR: cc_met = !st[ABBE_ST_Z];
         default: cc_met = 1'b0;
      endcase
   endfunction : cc_met

   ///////////////////////////////////////////////////////////////////////
   // Field extraction and class.
   always_comb begin
      dest = opcode[9];
      acc = opcode[8];
      bit_idx = opcode[11:9];
      faddr = opcode[7:0];
      br_ofs = opcode[7:0];
      br_take = 1'b0;
      if (opcode[15:10] == ABBE_PFX_AND) begin
         op = ABBE_OP_AND;
      end else if (opcode[15:12] == ABBE_PFX_BCLR) begin
         op = ABBE_OP_BCLR;
      end else if (opcode[15:11] == ABBE_PFX_BR && cc_known(opcode[10:8])) begin
         op = ABBE_OP_BR;
         br_take = cc_met(opcode[10:8], status);
      end else begin
         op = ABBE_OP_NONE;
      end
   end

endmodule : abbe_decode

`default_nettype wire

/* src/abbe_exec.sv */
// Execution slice: AND working register with file, file bit clear and
// flag-conditional relative branches, run on four quadrature phases.
// Assumes instructions are offered on instr_word/instr_valid and sampled
// in phase Q1; software reaches the state over a plain register port.
`timescale 1ns/10ps
`default_nettype none

module abbe_exec (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Instruction fetch.
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   output logic [abbe_pkg::ABBE_PC_W-1:0] fetch_addr,
   output logic exec_start,
   output logic flush_nop,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   import abbe_pkg::*;

   ///////////////////////////////////////////////////////////////////////
   // State.
   abbe_phase_t phase_r;
   logic [15:0] opcode_r;
   logic live_r;
   logic flush_r;
   logic start_r;
   logic [ABBE_PC_W-1:0] pc_r;
   logic [7:0] work_r;
   logic [3:0] bank_r;
   logic [ABBE_ST_W-1:0] stat_r;
   logic [1:0] ctrl_r;
   logic [ABBE_FA_W-1:0] idx_r;
   logic [ABBE_FA_W-1:0] fptr_r;
   logic [ABBE_FA_W-1:0] ea_r;
   logic [7:0] operand_r;
   logic [7:0] result_r;
   logic take_r;
   logic [31:0] rdata_r;
   logic [7:0] file_mem [0:(1<<ABBE_FA_W)-1];

   abbe_op_t dec_op;
   logic dec_dest;
   logic dec_acc;
   logic [2:0] dec_bit;
   logic [7:0] dec_faddr;
   logic [7:0] dec_ofs;
   logic dec_take;
   logic [ABBE_FA_W-1:0] ea_nxt;
   logic [ABBE_PC_W-1:0] br_step;
   logic accept;
   logic core_wr;
   logic wr_file;
   logic wr_work;
   logic sw_ctrl;
   logic sw_work;
   logic sw_bank;
   logic sw_stat;
   logic sw_pc;
   logic sw_idx;
   logic sw_fptr;
   logic sw_fdata;

   abbe_decode u_decode (
      .opcode(opcode_r),
      .status(stat_r),
      .op(dec_op),
      .dest(dec_dest),
      .acc(dec_acc),
      .bit_idx(dec_bit),
      .faddr(dec_faddr),
      .br_ofs(dec_ofs),
      .br_take(dec_take)
   );

   ///////////////////////////////////////////////////////////////////////
   // Effective file address from the access bit, bank and extended mode.
   function automatic logic [ABBE_FA_W-1:0] eff_addr(
      input logic a,
      input logic [7:0] f,
      input logic [3:0] bank,
      input logic ext,
      input logic [ABBE_FA_W-1:0] base
   );
      if (a) begin
         eff_addr = {bank, f};
      end else if (ext && f <= ABBE_IDX_LIMIT) begin
         eff_addr = base + {4'h0, f};
      end else if (f < ABBE_ACC_SPLIT) begin
         eff_addr = {ABBE_ACC_LO_BANK, f};
      end else begin
         eff_addr = {ABBE_ACC_HI_BANK, f};
      end
   endfunction : eff_addr

   always_comb begin
      ea_nxt = eff_addr(dec_acc, dec_faddr, bank_r, ctrl_r[ABBE_CTRL_EXT], idx_r);
      br_step = {{(ABBE_PC_W-9){dec_ofs[7]}}, dec_ofs, 1'b0};
      accept = (phase_r == ABBE_Q1) && instr_valid && ctrl_r[ABBE_CTRL_RUN] &&
               !flush_r;
      core_wr = (phase_r == ABBE_Q4) && live_r;
      wr_file = core_wr && ((dec_op == ABBE_OP_AND && dec_dest) ||
                            dec_op == ABBE_OP_BCLR);
      wr_work = core_wr && dec_op == ABBE_OP_AND && !dec_dest;
   end

   ///////////////////////////////////////////////////////////////////////
   // Software write strobes, one per writable register (none for EXEC); a core update in the same
   // edge takes priority over them in each register's own process.
   always_comb begin
      sw_ctrl = 1'b0;
      sw_work = 1'b0;
      sw_bank = 1'b0;
      sw_stat = 1'b0;
      sw_pc = 1'b0;
      sw_idx = 1'b0;
      sw_fptr = 1'b0;
      sw_fdata = 1'b0;
      if (reg_wr) begin
         if (reg_addr == ABBE_REG_CTRL) begin
            sw_ctrl = 1'b1;
         end else if (reg_addr == ABBE_REG_WORK) begin
            sw_work = 1'b1;
         end else if (reg_addr == ABBE_REG_BANK) begin
            sw_bank = 1'b1;
         end else if (reg_addr == ABBE_REG_STAT) begin
            sw_stat = 1'b1;
         end else if (reg_addr == ABBE_REG_PC) begin
            sw_pc = 1'b1;
         end else if (reg_addr == ABBE_REG_IDX) begin
            sw_idx = 1'b1;
         end else if (reg_addr == ABBE_REG_FPTR) begin
            sw_fptr = 1'b1;
         end else if (reg_addr == ABBE_REG_FDATA) begin
            sw_fdata = 1'b1;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Quadrature phase sequencer.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= ABBE_Q1;
      end else begin
         case (phase_r)
            ABBE_Q1: phase_r <= ABBE_Q2;
            ABBE_Q2: phase_r <= ABBE_Q3;
            ABBE_Q3: phase_r <= ABBE_Q4;
            ABBE_Q4: phase_r <= ABBE_Q1;
            default: phase_r <= ABBE_Q1;
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Instruction capture in Q1.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opcode_r <= 16'h0000;
         live_r <= 1'b0;
         start_r <= 1'b0;
      end else begin
         start_r <= accept;
         if (phase_r == ABBE_Q1) begin
            live_r <= accept;
            if (accept) begin
               opcode_r <= instr_word;
            end
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Forced no-operation cycle after a taken branch.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flush_r <= 1'b0;
      end else if (core_wr && dec_op == ABBE_OP_BR && take_r) begin
         flush_r <= 1'b1;
      end else if (phase_r == ABBE_Q4) begin
         flush_r <= 1'b0;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Operand read in Q2, processing in Q3.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ea_r <= 12'h000;
         operand_r <= 8'h00;
         result_r <= 8'h00;
         take_r <= 1'b0;
      end else begin
         if (phase_r == ABBE_Q2) begin
            ea_r <= ea_nxt;
            operand_r <= file_mem[ea_nxt];
         end
         if (phase_r == ABBE_Q3) begin
            take_r <= dec_take;
            if (dec_op == ABBE_OP_BCLR) begin
               result_r <= operand_r & ~(8'h01 << dec_bit);
            end else begin
               result_r <= work_r & operand_r;
            end
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Program counter: step on fetch, relative jump in Q4 when taken.
   // A software write in the same edge as either of those is lost.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_r <= ABBE_PC_RST;
      end else if (accept) begin
         pc_r <= pc_r + ABBE_PC_STEP;
      end else if (core_wr && dec_op == ABBE_OP_BR && take_r) begin
         pc_r <= pc_r + br_step;
      end else if (sw_pc) begin
         pc_r <= reg_wdata[ABBE_PC_W-1:0];
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Working register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         work_r <= ABBE_WORK_RST;
      end else if (wr_work) begin
         work_r <= result_r;
      end else if (sw_work) begin
         work_r <= reg_wdata[7:0];
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Status flags; of the instructions only AND touches them, and only N and Z.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= ABBE_STAT_RST;
      end else if (core_wr && dec_op == ABBE_OP_AND) begin
         stat_r[ABBE_ST_N] <= result_r[7];
         stat_r[ABBE_ST_Z] <= (result_r == 8'h00);
      end else if (sw_stat) begin
         stat_r <= reg_wdata[ABBE_ST_W-1:0];
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Software-owned configuration.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= ABBE_CTRL_RST;
         bank_r <= ABBE_BANK_RST;
         idx_r <= ABBE_IDX_RST;
         fptr_r <= 12'h000;
      end else begin
         if (sw_ctrl) begin
            ctrl_r <= reg_wdata[1:0];
         end else if (sw_bank) begin
            bank_r <= reg_wdata[3:0];
         end else if (sw_idx) begin
            idx_r <= reg_wdata[ABBE_FA_W-1:0];
         end else if (sw_fptr) begin
            fptr_r <= reg_wdata[ABBE_FA_W-1:0];
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // File memory; the core write in Q4 wins over a software write.
   always_ff @(posedge clk) begin
      if (wr_file) begin
         file_mem[ea_r] <= result_r;
      end else if (sw_fdata) begin
         file_mem[fptr_r] <= reg_wdata[7:0];
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Register read port: data stands for one cycle after the strobe.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h00000000;
      end else if (!reg_rd) begin
         rdata_r <= 32'h00000000;
      end else if (reg_addr == ABBE_REG_CTRL) begin
         rdata_r <= {30'h0, ctrl_r};
      end else if (reg_addr == ABBE_REG_WORK) begin
         rdata_r <= {24'h000000, work_r};
      end else if (reg_addr == ABBE_REG_BANK) begin
         rdata_r <= {28'h0000000, bank_r};
      end else if (reg_addr == ABBE_REG_STAT) begin
         rdata_r <= {27'h0, stat_r};
      end else if (reg_addr == ABBE_REG_PC) begin
         rdata_r <= {16'h0000, pc_r};
      end else if (reg_addr == ABBE_REG_IDX) begin
         rdata_r <= {20'h00000, idx_r};
      end else if (reg_addr == ABBE_REG_FPTR) begin
         rdata_r <= {20'h00000, fptr_r};
      end else if (reg_addr == ABBE_REG_FDATA) begin
         rdata_r <= {24'h000000, file_mem[fptr_r]};
      end else if (reg_addr == ABBE_REG_EXEC) begin
         rdata_r <= {22'h0, dec_op, live_r, flush_r, phase_r};
      end else begin
         rdata_r <= 32'h00000000;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Outputs.
   assign fetch_addr = pc_r;
   assign exec_start = start_r;
   assign flush_nop = flush_r;
   assign reg_rdata = rdata_r;

endmodule : abbe_exec

`default_nettype wire

/* test/abbe_exec_sva.sv */
// Checker for the execution slice: fetch, start and forced no-op timing.
// Assumes the phase counter starts at Q1 on the first edge after reset.
`timescale 1ns/10ps
`default_nettype none

module abbe_exec_chk (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Instruction fetch.
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   input wire logic [abbe_pkg::ABBE_PC_W-1:0] fetch_addr,
   input wire logic exec_start,
   input wire logic flush_nop,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   import abbe_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helper logic; ph_r is zero in the cycle that ends on a Q1 edge.
   logic [1:0] ph_r;
   logic [4:0] pfx;
   logic [15:0] ofs2;
   logic pc_wr;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_r <= 2'h0;
      end else begin
         ph_r <= ph_r + 2'h1;
      end
   end
   assign pfx = instr_word[15:11];
   assign ofs2 = {{7{instr_word[7]}}, instr_word[7:0], 1'b0};
   assign pc_wr = reg_wr && (reg_addr == ABBE_REG_PC);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////
   // Assertions.
   AST_START_CAUSE: assert property (exec_start |-> $past(instr_valid) &&
      $past(ph_r) == 2'h0 && !$past(flush_nop)) else $error("start without Q1 offer");
   AST_START_GAP: assert property (exec_start |=> !exec_start [*3])
      else $error("starts closer than one instruction cycle");
   AST_PC_STEP: assert property (exec_start |->
      fetch_addr == $past(fetch_addr) + ABBE_PC_STEP) else $error("pc did not step by 2");
   AST_PC_HOLD: assert property (!exec_start && !$rose(flush_nop) && !$past(pc_wr)
      |-> $stable(fetch_addr)) else $error("pc changed without cause");
   AST_FLUSH_LEN: assert property ($rose(flush_nop) |-> flush_nop [*4] ##1 !flush_nop)
      else $error("no-op cycle not four clocks");
   AST_FLUSH_CAUSE: assert property ($rose(flush_nop) |-> $past(exec_start, 3) &&
      $past(pfx, 4) == ABBE_PFX_BR) else $error("no-op cycle without branch");
   AST_FLUSH_Q1: assert property ($rose(flush_nop) |-> ph_r == 2'h0)
      else $error("no-op cycle not phase aligned");
   AST_FLUSH_NOSTART: assert property (flush_nop |-> !exec_start)
      else $error("instruction accepted in no-op cycle");
   AST_BR_TARGET: assert property ($rose(flush_nop) |->
      fetch_addr == $past(fetch_addr) + $past(ofs2, 4)) else $error("bad branch target");

   COV_START: cover property (exec_start);
   COV_FLUSH: cover property ($rose(flush_nop));
   COV_READ: cover property ($past(reg_rd) && reg_rdata != 32'h0);
endmodule : abbe_exec_chk

bind abbe_exec abbe_exec_chk u_chk (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
   .instr_valid(instr_valid), .fetch_addr(fetch_addr), .exec_start(exec_start),
   .flush_nop(flush_nop), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata));

`default_nettype wire

/* test/abbe_testbench.sv */
// Self-checking bench for the execution slice, driven over its register port and instr_word/instr_valid.
// Assumes file memory is loaded through FPTR/FDATA before each AND or bit-clear instruction.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
   $display("BAD %0t got %h exp %h", $time, got, exp); end end

module testbench;
   import abbe_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic instr_valid = 1'b0;
   logic [ABBE_PC_W-1:0] fetch_addr;
   logic exec_start;
   logic flush_nop;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] rd_v;
   logic [1:0] ph = 2'h0;
   logic [7:0] n;
   logic [4:0] s;
   logic [15:0] exp_pc;
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   int i;
   int t;
   logic [2:0] cc_tab [6] = '{ABBE_CC_CSET, ABBE_CC_NSET, ABBE_CC_CCLR, ABBE_CC_NCLR,
      ABBE_CC_OCLR, ABBE_CC_ZCLR};
   int bit_tab [6] = '{ABBE_ST_C, ABBE_ST_N, ABBE_ST_C, ABBE_ST_N, ABBE_ST_OVF, ABBE_ST_Z};
   logic lvl_tab [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

   abbe_exec uut (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
      .instr_valid(instr_valid), .fetch_addr(fetch_addr), .exec_start(exec_start),
      .flush_nop(flush_nop), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   always #2.5 clk = ~clk;

   // Old value 3 at an edge means that edge was Q4 and the next is Q1.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) ph <= 2'h0;
      else ph <= ph + 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Tasks; each starts and ends just after a rising edge.
   task automatic print_verdict();
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      // The strobe stays up; the next read or issue lowers it.
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      reg_wr <= 1'b0;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
      `CHK(rd_v, e)
      @(posedge clk);
   endtask : rchk

   task automatic fset(input logic [11:0] a, input logic [7:0] d);
      wr(ABBE_REG_FPTR, 32'(a));
      wr(ABBE_REG_FDATA, 32'(d));
   endtask : fset

   task automatic fchk(input logic [11:0] a, input logic [7:0] e);
      wr(ABBE_REG_FPTR, 32'(a));
      rchk(ABBE_REG_FDATA, 32'(e));
   endtask : fchk

   // Offers one word at a Q1 edge and counts no-op clocks over two cycles.
   task automatic issue(input logic [15:0] w, input int nflush);
      int k;
      int f;
      f = 0;
      reg_wr <= 1'b0;
      do @(posedge clk); while (ph != 2'h3);
      instr_word <= w;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      for (k = 0; k < 8; k++) begin
         #1;
         if (flush_nop !== 1'b0) f++;
         @(posedge clk);
      end
      `CHK(f, nflush)
   endtask : issue

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rchk(ABBE_REG_CTRL, 32'(ABBE_CTRL_RST));
      rchk(ABBE_REG_WORK, 32'(ABBE_WORK_RST));
      rchk(ABBE_REG_BANK, 32'(ABBE_BANK_RST));
      rchk(ABBE_REG_STAT, 32'(ABBE_STAT_RST));
      rchk(ABBE_REG_PC, 32'(ABBE_PC_RST));
      rchk(ABBE_REG_IDX, 32'(ABBE_IDX_RST));
      rchk(8'hFC, 32'h0);
      rchk(ABBE_REG_EXEC, 32'h00000044);
      wr(ABBE_REG_CTRL, 32'h1);
      wr(ABBE_REG_BANK, 32'h3);
      fset(12'h3A5, 8'hC2);
      wr(ABBE_REG_WORK, 32'h17);
      wr(ABBE_REG_STAT, 32'h0F);
      issue(16'h15A5, 0);
      rchk(ABBE_REG_WORK, 32'h02);
      rchk(ABBE_REG_STAT, 32'h0B);
      fchk(12'h3A5, 8'hC2);
      fset(12'hF70, 8'h0F);
      wr(ABBE_REG_WORK, 32'hF0);
      wr(ABBE_REG_STAT, 32'h10);
      issue(16'h1670, 0);
      rchk(ABBE_REG_WORK, 32'hF0);
      fchk(12'hF70, 8'h00);
      rchk(ABBE_REG_STAT, 32'h04);
      fset(12'h020, 8'hFF);
      wr(ABBE_REG_STAT, 32'h1F);
      issue(16'h9620, 0);
      fchk(12'h020, 8'hF7);
      rchk(ABBE_REG_STAT, 32'h1F);
      wr(ABBE_REG_CTRL, 32'h3);
      wr(ABBE_REG_IDX, 32'h200);
      fset(12'h25F, 8'hC7);
      issue(16'h9E5F, 0);
      fchk(12'h25F, 8'h47);
      fset(12'hF60, 8'hFF);
      fset(12'h260, 8'hFF);
      issue(16'h9060, 0);
      fchk(12'hF60, 8'hFE);
      fchk(12'h260, 8'hFF);
      wr(ABBE_REG_PC, 32'h1000);
      issue(16'hE47F, 0);
      rchk(ABBE_REG_PC, 32'h1002);
      for (i = 0; i < 6; i++) begin
         for (t = 0; t < 2; t++) begin
            n = i[0] ? 8'h80 : 8'h7F;
            s = 5'h01 << bit_tab[i];
            if ((lvl_tab[i] ^ t[0]) == 1'b0) s = ~s;
            wr(ABBE_REG_STAT, 32'(s));
            wr(ABBE_REG_PC, 32'h1000);
            issue({ABBE_PFX_BR, cc_tab[i], n}, t ? 0 : 4);
            exp_pc = t ? 16'h1002 : 16'h1002 + {{7{n[7]}}, n, 1'b0};
            rchk(ABBE_REG_PC, 32'(exp_pc));
            rchk(ABBE_REG_STAT, 32'(s));
         end
      end
      print_verdict();
   end
endmodule : testbench

`default_nettype wire
